// ==== verif/supervisor_asserts.sv ====
// port checker for the supply supervisor mode control block
// assumes it is bound into supply_supervisor_mode_control on one aclk domain
`timescale 1ns/100ps
module supervisor_asserts (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // mode and comparators
   input wire logic deep_mode,
   input wire logic low_sup_trip,
   input wire logic low_mon_trip,
   input wire logic high_sup_trip,
   input wire logic high_over_trip,
   // results
   input wire logic [1:0] low_sup_level,
   input wire logic [1:0] low_mon_level,
   input wire logic [1:0] high_sup_level,
   input wire logic [1:0] high_mon_level,
   input wire logic por_request,
   input wire logic irq
);
   ////////////////////////////////////////////////////////////////
   // trip history covers the synchronizer and event register delay
   logic [7:0] trip_hist_q;
   logic [3:0] quiet_q;
   logic deep_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) trip_hist_q <= 8'h00;
      else trip_hist_q <= {trip_hist_q[6:0], low_sup_trip | low_mon_trip | high_sup_trip | high_over_trip};
   end
   always_ff @(posedge aclk) begin
      deep_q <= deep_mode;
   end
   // levels may only move shortly after a write or a mode change
   always_ff @(posedge aclk) begin
      if (!aresetn || s_axi_awvalid || s_axi_bvalid || deep_mode != deep_q) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while response pending");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_level_legal: assert property (low_sup_level != 2'h3 && low_mon_level != 2'h3 && high_sup_level != 2'h3
      && high_mon_level != 2'h3) else $error("illegal unit level");
   a_reset_levels: assert property ($rose(aresetn) |-> ##[1:2] (low_sup_level == 2'h2 && high_sup_level == 2'h1
      && low_mon_level == 2'h0 && high_mon_level == 2'h0)) else $error("levels wrong after reset");
   a_levels_steady: assert property (quiet_q > 4'h6 |-> $stable({low_sup_level, low_mon_level,
      high_sup_level, high_mon_level})) else $error("level moved without cause");
   a_por_cause: assert property (por_request |-> trip_hist_q != 8'h00)
      else $error("reset request without comparator event");
   c_por: cover property ($rose(por_request));
   c_irq: cover property ($rose(irq));
   c_deep_off: cover property (deep_mode && high_mon_level == 2'h0 && low_sup_level == 2'h1);
endmodule
bind supply_supervisor_mode_control supervisor_asserts supervisor_asserts_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .deep_mode(deep_mode),
   .low_sup_trip(low_sup_trip), .low_mon_trip(low_mon_trip), .high_sup_trip(high_sup_trip),
   .high_over_trip(high_over_trip), .low_sup_level(low_sup_level), .low_mon_level(low_mon_level),
   .high_sup_level(high_sup_level), .high_mon_level(high_mon_level), .por_request(por_request), .irq(irq)
);

// ==== verif/testbench.sv ====
// self-checking bench for the supply supervisor mode control block
// assumes the block alone, driven through its bus and comparator ports
`timescale 1ns/100ps
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic deep = 1'b0, ls_trip = 1'b0, lm_trip = 1'b0, hm_trip = 1'b0, ov_trip = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, slow_wakeup, por_request, irq;
   logic [1:0] bresp, rresp, rs, ls_lvl, lm_lvl, hs_lvl, hm_lvl;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   supply_supervisor_mode_control supply_supervisor_mode_control_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .deep_mode(deep), .low_sup_trip(ls_trip),
      .low_mon_trip(lm_trip), .high_sup_trip(1'b0), .high_mon_trip(hm_trip), .high_over_trip(ov_trip),
      .low_sup_level(ls_lvl), .low_mon_level(lm_lvl), .high_sup_level(hs_lvl), .high_mon_level(hm_lvl),
      .slow_wakeup(slow_wakeup), .por_request(por_request), .irq(irq));
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      int n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // polling costs a few cycles, so the end of settling is judged in a window
   task automatic settle(input int b, input int len);
      int t0 = cyc;
      int n = 0;
      rdr(supervisor_pkg::FLAGS_OFF);
      check(rd[b], 1'b1);
      repeat (len - 20) @(posedge aclk);
      rdr(supervisor_pkg::FLAGS_OFF);
      check(rd[b], 1'b1);
      do begin
         rdr(supervisor_pkg::FLAGS_OFF);
         n++;
      end while (rd[b] !== 1'b0 && n < 20);
      check(cyc - t0 >= len - 6 && cyc - t0 <= len + 10, 1'b1);
   endtask
   task automatic set_deep(input logic d);
      @(posedge aclk);
      deep <= d;
      repeat (6) @(posedge aclk);
   endtask
   task automatic trips(input logic [3:0] v);
      @(posedge aclk);
      {lm_trip, ls_trip, hm_trip, ov_trip} <= v;
      repeat (8) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdr(supervisor_pkg::LOW_CTL_OFF);
      check(rd, 32'h05);
      rdr(supervisor_pkg::HIGH_CTL_OFF);
      check(rd, 32'h01);
      check({ls_lvl, lm_lvl, hs_lvl, hm_lvl, slow_wakeup}, 9'h108);
      rdr(8'h1C);
      check(rs, 2'h2);
      wr(8'h1C, 32'h0, rs);
      check(rs, 2'h2);
   endtask
   task automatic t_settle();
      wr(supervisor_pkg::LOW_CTL_OFF, 32'h05, rs);
      settle(supervisor_pkg::LOW_DLY_BIT, 400);
      wr(supervisor_pkg::LOW_CTL_OFF, 32'h01, rs);
      settle(supervisor_pkg::LOW_DLY_BIT, 30000);
      check(slow_wakeup, 1'b1);
      rdr(supervisor_pkg::FLAGS_OFF);
      check(rd[1:0], 2'h0);
      set_deep(1'b1);
      check({ls_lvl, hs_lvl}, 4'h0);
      set_deep(1'b0);
      check({ls_lvl, hs_lvl}, 4'h5);
   endtask
   task automatic t_auto();
      wr(supervisor_pkg::LOW_CTL_OFF, 32'h27, rs);
      settle(supervisor_pkg::LOW_DLY_BIT, 400);
      wr(supervisor_pkg::HIGH_CTL_OFF, 32'h29, rs);
      settle(supervisor_pkg::HIGH_DLY_BIT, 30000);
      check({ls_lvl, hs_lvl, hm_lvl, slow_wakeup}, 7'h4A);
      set_deep(1'b1);
      check({ls_lvl, hs_lvl, hm_lvl}, 6'h10);
      set_deep(1'b0);
   endtask
   task automatic t_manual();
      wr(supervisor_pkg::LOW_CTL_OFF, 32'h07, rs);
      settle(supervisor_pkg::LOW_DLY_BIT, 400);
      wr(supervisor_pkg::HIGH_CTL_OFF, 32'h0F, rs);
      settle(supervisor_pkg::HIGH_DLY_BIT, 400);
      set_deep(1'b1);
      check({ls_lvl, hs_lvl, hm_lvl}, 6'h29);
      set_deep(1'b0);
   endtask
   task automatic t_irq();
      wr(supervisor_pkg::IRQ_ENABLE_OFF, 32'h24, rs);
      trips(4'h6);
      check({irq, por_request}, 2'h2);
      wr(supervisor_pkg::IRQ_CLEAR_OFF, 32'h24, rs);
      rdr(supervisor_pkg::IRQ_STATUS_OFF);
      check(rd, 32'h24);
      trips(4'h0);
      wr(supervisor_pkg::IRQ_ENABLE_OFF, 32'h0, rs);
      check(irq, 1'b0);
      wr(supervisor_pkg::IRQ_ENABLE_OFF, 32'h24, rs);
      check(irq, 1'b1);
      wr(supervisor_pkg::IRQ_CLEAR_OFF, 32'h24, rs);
      rdr(supervisor_pkg::IRQ_STATUS_OFF);
      check(rd, 32'h0);
      check(irq, 1'b0);
   endtask
   task automatic t_por();
      wr(supervisor_pkg::LOW_CTL_OFF, 32'h47, rs);
      settle(supervisor_pkg::LOW_DLY_BIT, 400);
      trips(4'h4);
      check(por_request, 1'b1);
      trips(4'h0);
      check(por_request, 1'b0);
      wr(supervisor_pkg::LOW_CTL_OFF, 32'h8F, rs);
      settle(supervisor_pkg::LOW_DLY_BIT, 400);
      trips(4'h8);
      check(por_request, 1'b1);
      trips(4'h0);
      check(por_request, 1'b0);
      wr(supervisor_pkg::HIGH_CTL_OFF, 32'h4D, rs);
      settle(supervisor_pkg::HIGH_DLY_BIT, 400);
      trips(4'h1);
      check(por_request, 1'b1);
      rdr(supervisor_pkg::IRQ_STATUS_OFF);
      check(rd, 32'h40);
      trips(4'h0);
      check(por_request, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_settle();
      t_auto();
      t_manual();
      t_irq();
      t_por();
      conclude();
   end
endmodule

// ==== verilog/settle_if.sv ====
// carrier between mode control and its settling timer
// assumes both ends on aclk
`timescale 1ns/100ps
interface settle_if;
   logic start;
   logic slow;
   logic busy;
   modport ctrl (output start, output slow, input busy);
   modport timer (input start, input slow, output busy);
endinterface

// ==== verilog/settle_timer.sv ====
// settling delay timer for one supervisor side
// assumes start is a one-cycle pulse on aclk
`timescale 1ns/100ps
module settle_timer #(
   parameter int FAST_CYC = supervisor_pkg::SETTLE_FAST_CYC,
   parameter int SLOW_CYC = supervisor_pkg::SETTLE_SLOW_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   settle_if.timer sif
);
   if (SLOW_CYC >= (1 << supervisor_pkg::CNT_WIDTH) || FAST_CYC < 1) begin : g_bad_count
      $error("settle_timer: count does not fit");
   end
   logic [supervisor_pkg::CNT_WIDTH-1:0] cnt_q;
   // a restart mid-delay reloads, so the latest setting always gets its full delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (sif.start) begin
         cnt_q <= sif.slow ? supervisor_pkg::CNT_WIDTH'(SLOW_CYC) : supervisor_pkg::CNT_WIDTH'(FAST_CYC);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   assign sif.busy = (cnt_q != '0);
endmodule

// ==== verilog/supervisor_pkg.sv ====
// package for the supply supervisor mode control block
// assumes a 200 MHz aclk and a 32-bit axi4-lite register bus
package supervisor_pkg;
   // register byte offsets
   localparam logic [7:0] LOW_CTL_OFF = 8'h00;
   localparam logic [7:0] HIGH_CTL_OFF = 8'h04;
   localparam logic [7:0] FLAGS_OFF = 8'h08;
   localparam logic [7:0] IRQ_STATUS_OFF = 8'h0C;
   localparam logic [7:0] IRQ_ENABLE_OFF = 8'h10;
   localparam logic [7:0] IRQ_CLEAR_OFF = 8'h14;
   localparam logic [7:0] MODE_OFF = 8'h18;
   // low-side control fields
   localparam int LOW_SUP_EN_BIT = 0;
   localparam int LOW_SUP_LPM_BIT = 1;
   localparam int LOW_SUP_FP_BIT = 2;
   localparam int LOW_MON_EN_BIT = 3;
   localparam int LOW_MON_FP_BIT = 4;
   localparam int LOW_AUTO_BIT = 5;
   localparam int LOW_SUP_RST_BIT = 6;
   localparam int LOW_MON_RST_BIT = 7;
   // high-side control fields
   localparam int HIGH_SUP_EN_BIT = 0;
   localparam int HIGH_SUP_LPM_BIT = 1;
   localparam int HIGH_SUP_FP_BIT = 2;
   localparam int HIGH_MON_EN_BIT = 3;
   localparam int HIGH_MON_FP_BIT = 4;
   localparam int HIGH_AUTO_BIT = 5;
   localparam int HIGH_OVP_BIT = 6;
   localparam int CTL_WIDTH = 8;
   // flag / status layout
   localparam int LOW_DLY_BIT = 0;
   localparam int HIGH_DLY_BIT = 1;
   localparam int LOW_SUP_EV_BIT = 2;
   localparam int LOW_MON_EV_BIT = 3;
   localparam int HIGH_SUP_EV_BIT = 4;
   localparam int HIGH_MON_EV_BIT = 5;
   localparam int OVP_EV_BIT = 6;
   localparam int IRQ_WIDTH = 7;
   // reset values
   localparam logic [7:0] LOW_CTL_RESET = 8'h05;
   localparam logic [7:0] HIGH_CTL_RESET = 8'h01;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int SETTLE_FAST_NS = 2000;
   localparam int SETTLE_SLOW_NS = 150000;
   localparam int SETTLE_FAST_CYC = (SETTLE_FAST_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_SLOW_CYC = (SETTLE_SLOW_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_WIDTH = 16;
   // unit operating level
   typedef enum logic [1:0] {
      UNIT_OFF = 2'b00,
      UNIT_NORMAL = 2'b01,
      UNIT_FULL = 2'b10
   } unit_level_t;
   // bus states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_RESP = 2'b01
   } bus_state_t;
endpackage

// ==== verilog/supply_supervisor_mode_control.sv ====
// supply supervisor and monitor mode control with axi4-lite registers
// assumes comparator outputs and mode inputs arrive asynchronously
//
// Behaviour
// RL1 - low side gives fast wakeup when off or full, slow when normal
// RL2 - full-performance low supervisor settles in about two microseconds
// RL3 - normal-performance low supervisor settles in about 150 microseconds
// RL4 - slow wakeup selection lengthens deep-mode wakeup to about 150 microseconds
// RL5 - settle flags stay set while settling, read zero when finished
// RL6 - software waits for both settle flags clear before deep modes
// RL7 - high normal unit turns off in deep modes under auto or lpm clear
// RL8 - manual control with lpm enable keeps active-mode level in deep modes
// RL9 - high auto control makes high monitor inactive in deep modes; the code drops a full-performance high monitor to normal instead
// RL10 - overvoltage enable makes high monitor raise power-on reset above threshold
// RL11 - software selects normal low supervisor before raising core level
// RL12 - low side event causes reset or interrupt per configuration
// RL13 - control write sets settle flag and starts delay for new level
// RL14 - auto control drops full low supervisor to normal in deep modes
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module supply_supervisor_mode_control (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // power mode and comparators
   input wire logic deep_mode,
   input wire logic low_sup_trip,
   input wire logic low_mon_trip,
   input wire logic high_sup_trip,
   input wire logic high_mon_trip,
   input wire logic high_over_trip,
   // unit levels and results
   output logic [1:0] low_sup_level,
   output logic [1:0] low_mon_level,
   output logic [1:0] high_sup_level,
   output logic [1:0] high_mon_level,
   output logic slow_wakeup,
   output logic por_request,
   output logic irq
);
   //////////////////////////////////////////////////////////////////////////////
   // level decode shared by all four units
   function automatic supervisor_pkg::unit_level_t unit_level(input logic en, input logic fp,
         input logic lpm_en, input logic auto_ctl, input logic deep, input logic is_mon);
      supervisor_pkg::unit_level_t act;
      act = !en ? supervisor_pkg::UNIT_OFF : (fp ? supervisor_pkg::UNIT_FULL : supervisor_pkg::UNIT_NORMAL);
      if (!deep || act == supervisor_pkg::UNIT_OFF) begin
         return act;
      end
      // monitors have no lpm enable; a supervisor without it is off in deep modes, auto or not
      if (!is_mon && !lpm_en) begin
         return supervisor_pkg::UNIT_OFF; // RL7
      end
      if (auto_ctl) begin
         // full drops to normal, normal switches off
         return (act == supervisor_pkg::UNIT_FULL) ? supervisor_pkg::UNIT_NORMAL : supervisor_pkg::UNIT_OFF; // RL14 RL9 RL7
      end
      return act; // RL8
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {high_over_trip, high_mon_trip, high_sup_trip, low_mon_trip, low_sup_trip, deep_mode};
         sync2_q <= sync1_q;
      end
   end
   logic deep_s;
   assign deep_s = sync2_q[0];

   //////////////////////////////////////////////////////////////////////////////
   // bus slave
   logic [7:0] aw_addr_q;
   logic aw_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_have_q;
   supervisor_pkg::bus_state_t wr_state_q;
   logic wr_fire;
   logic [7:0] wr_addr;
   assign s_axi_awready = !aw_have_q && wr_state_q == supervisor_pkg::BUS_IDLE;
   assign s_axi_wready = !w_have_q && wr_state_q == supervisor_pkg::BUS_IDLE;
   assign wr_fire = aw_have_q && w_have_q && wr_state_q == supervisor_pkg::BUS_IDLE;
   assign wr_addr = aw_addr_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_have_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         wr_state_q <= supervisor_pkg::BUS_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         unique case (wr_state_q)
            supervisor_pkg::BUS_IDLE: begin
               if (wr_fire) begin
                  aw_have_q <= 1'b0;
                  w_have_q <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_known(wr_addr) ? 2'h0 : 2'h2;
                  wr_state_q <= supervisor_pkg::BUS_RESP;
               end
            end
            supervisor_pkg::BUS_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_q <= supervisor_pkg::BUS_IDLE;
               end
            end
            default: wr_state_q <= supervisor_pkg::BUS_IDLE;
         endcase
      end
   end

   function automatic logic wr_known(input logic [7:0] a);
      return a == supervisor_pkg::LOW_CTL_OFF || a == supervisor_pkg::HIGH_CTL_OFF ||
         a == supervisor_pkg::IRQ_ENABLE_OFF || a == supervisor_pkg::IRQ_CLEAR_OFF;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // control registers
   logic [7:0] low_ctl_q;
   logic [7:0] high_ctl_q;
   logic [6:0] irq_en_q;
   logic low_wr;
   logic high_wr;
   assign low_wr = wr_fire && wr_addr == supervisor_pkg::LOW_CTL_OFF && w_strb_q[0];
   assign high_wr = wr_fire && wr_addr == supervisor_pkg::HIGH_CTL_OFF && w_strb_q[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_ctl_q <= supervisor_pkg::LOW_CTL_RESET;
         high_ctl_q <= supervisor_pkg::HIGH_CTL_RESET;
         irq_en_q <= 7'h00;
      end else begin
         if (low_wr) begin
            low_ctl_q <= w_data_q[7:0];
         end
         if (high_wr) begin
            high_ctl_q <= w_data_q[7:0];
         end
         if (wr_fire && wr_addr == supervisor_pkg::IRQ_ENABLE_OFF && w_strb_q[0]) begin
            irq_en_q <= w_data_q[6:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // settling timers, one per side
   settle_if low_sif ();
   settle_if high_sif ();
   assign low_sif.start = low_wr; // RL13
   assign low_sif.slow = !w_data_q[supervisor_pkg::LOW_SUP_FP_BIT]; // RL2 RL3
   assign high_sif.start = high_wr; // RL13
   assign high_sif.slow = !w_data_q[supervisor_pkg::HIGH_SUP_FP_BIT];
   settle_timer u_low_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .sif(low_sif)
   );
   settle_timer u_high_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .sif(high_sif)
   );
   logic low_dly;
   logic high_dly;
   // flags track the timers, so they read zero in the same cycle the count reaches zero
   assign low_dly = low_sif.busy; // RL5
   assign high_dly = high_sif.busy; // RL5

   //////////////////////////////////////////////////////////////////////////////
   // unit levels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_sup_level <= supervisor_pkg::UNIT_OFF;
         low_mon_level <= supervisor_pkg::UNIT_OFF;
         high_sup_level <= supervisor_pkg::UNIT_OFF;
         high_mon_level <= supervisor_pkg::UNIT_OFF;
         slow_wakeup <= 1'b0;
      end else begin
         low_sup_level <= unit_level(low_ctl_q[supervisor_pkg::LOW_SUP_EN_BIT],
            low_ctl_q[supervisor_pkg::LOW_SUP_FP_BIT], low_ctl_q[supervisor_pkg::LOW_SUP_LPM_BIT],
            low_ctl_q[supervisor_pkg::LOW_AUTO_BIT], deep_s, 1'b0);
         low_mon_level <= unit_level(low_ctl_q[supervisor_pkg::LOW_MON_EN_BIT],
            low_ctl_q[supervisor_pkg::LOW_MON_FP_BIT], 1'b0,
            low_ctl_q[supervisor_pkg::LOW_AUTO_BIT], deep_s, 1'b1);
         high_sup_level <= unit_level(high_ctl_q[supervisor_pkg::HIGH_SUP_EN_BIT],
            high_ctl_q[supervisor_pkg::HIGH_SUP_FP_BIT], high_ctl_q[supervisor_pkg::HIGH_SUP_LPM_BIT],
            high_ctl_q[supervisor_pkg::HIGH_AUTO_BIT], deep_s, 1'b0); // RL7 RL8
         high_mon_level <= unit_level(high_ctl_q[supervisor_pkg::HIGH_MON_EN_BIT],
            high_ctl_q[supervisor_pkg::HIGH_MON_FP_BIT], 1'b0,
            high_ctl_q[supervisor_pkg::HIGH_AUTO_BIT], deep_s, 1'b1); // RL9
         // either low unit in normal performance forces the slow wakeup
         slow_wakeup <= (low_ctl_q[supervisor_pkg::LOW_SUP_EN_BIT] && !low_ctl_q[supervisor_pkg::LOW_SUP_FP_BIT]) ||
            (low_ctl_q[supervisor_pkg::LOW_MON_EN_BIT] && !low_ctl_q[supervisor_pkg::LOW_MON_FP_BIT]); // RL1 RL4
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // events: reset or interrupt
   logic low_sup_ev;
   logic low_mon_ev;
   logic high_sup_ev;
   logic high_mon_ev;
   logic ovp_ev;
   // comparators are ignored while their unit is off or still settling
   assign low_sup_ev = sync2_q[1] && low_sup_level != supervisor_pkg::UNIT_OFF && !low_dly;
   assign low_mon_ev = sync2_q[2] && low_mon_level != supervisor_pkg::UNIT_OFF && !low_dly;
   assign high_sup_ev = sync2_q[3] && high_sup_level != supervisor_pkg::UNIT_OFF && !high_dly;
   assign high_mon_ev = sync2_q[4] && high_mon_level != supervisor_pkg::UNIT_OFF && !high_dly;
   assign ovp_ev = sync2_q[5] && high_mon_level != supervisor_pkg::UNIT_OFF &&
      high_ctl_q[supervisor_pkg::HIGH_OVP_BIT] && !high_dly; // RL10
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_request <= 1'b0;
      end else begin
         por_request <= (low_sup_ev && low_ctl_q[supervisor_pkg::LOW_SUP_RST_BIT]) ||
            (low_mon_ev && low_ctl_q[supervisor_pkg::LOW_MON_RST_BIT]) || high_sup_ev || ovp_ev; // RL12 RL10
      end
   end

   logic [6:0] irq_status_q;
   logic [6:0] irq_set;
   logic [6:0] irq_clr;
   logic [6:0] flag_vec;
   assign flag_vec = {ovp_ev, high_mon_ev, high_sup_ev, low_mon_ev, low_sup_ev, high_dly, low_dly};
   assign irq_set = {ovp_ev, high_mon_ev && !high_ctl_q[supervisor_pkg::HIGH_OVP_BIT], 1'b0,
      low_mon_ev && !low_ctl_q[supervisor_pkg::LOW_MON_RST_BIT],
      low_sup_ev && !low_ctl_q[supervisor_pkg::LOW_SUP_RST_BIT], 1'b0, 1'b0}; // RL12
   assign irq_clr = (wr_fire && wr_addr == supervisor_pkg::IRQ_CLEAR_OFF && w_strb_q[0]) ? w_data_q[6:0] : 7'h00;
   // set beats clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= 7'h00;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      end
   end
   assign irq = |(irq_status_q & irq_en_q);

   //////////////////////////////////////////////////////////////////////////////
   // read channel
   function automatic logic [31:0] rd_value(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi,
         input logic [6:0] fl, input logic [6:0] st, input logic [6:0] en, input logic [9:0] md);
      unique case (a)
         supervisor_pkg::LOW_CTL_OFF: return {24'h000000, lo};
         supervisor_pkg::HIGH_CTL_OFF: return {24'h000000, hi};
         supervisor_pkg::FLAGS_OFF: return {25'h0000000, fl};
         supervisor_pkg::IRQ_STATUS_OFF: return {25'h0000000, st};
         supervisor_pkg::IRQ_ENABLE_OFF: return {25'h0000000, en};
         supervisor_pkg::MODE_OFF: return {22'h000000, md};
         default: return 32'h00000000;
      endcase
   endfunction

   function automatic logic rd_known(input logic [7:0] a);
      return a == supervisor_pkg::LOW_CTL_OFF || a == supervisor_pkg::HIGH_CTL_OFF ||
         a == supervisor_pkg::FLAGS_OFF || a == supervisor_pkg::IRQ_STATUS_OFF ||
         a == supervisor_pkg::IRQ_ENABLE_OFF || a == supervisor_pkg::MODE_OFF;
   endfunction

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value(s_axi_araddr, low_ctl_q, high_ctl_q, flag_vec, irq_status_q, irq_en_q,
            {deep_s, slow_wakeup, high_mon_level, high_sup_level, low_mon_level, low_sup_level});
         s_axi_rresp <= rd_known(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
